// [hdl/shared_interrupt_flag_aggregator.sv]
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module shared_interrupt_flag_aggregator
  import irq_agg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire src_flags_t src_event,
  input wire src_flags_t periph_clear,
  input wire logic adc_conv_done,
  input wire logic [PIN_N-1:0] pin_event,
  output logic ext_vector_zero,
  output logic ext_vector_one,
  output logic ext_vector_two,
  output logic ext_vector_three
);

  apb_req_t req;
  apb_state_t apb_state_reg;
  logic [IDX_W-1:0] req_idx;
  logic req_aligned;
  logic req_mapped;
  logic wr_fire;
  logic [DATA_W-1:0] rd_data;
  logic [BYTE_W-1:0] vec_enable_reg [3];
  logic [PIN_N-1:0] pin_enable_reg;
  src_flags_t src_flags_reg;
  src_flags_t src_clear;
  logic [PIN_N-1:0] pin_flags_reg;
  logic [PIN_N-1:0] pin_clear;
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;
  logic [3:0] vector_reg;

  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  assign req_idx = req.paddr[ADDR_W-1:2];
  assign req_aligned = (req.paddr[1:0] == 2'b00);

  always_comb begin
    rd_data = '0;
    req_mapped = req_aligned;
    unique case (req_idx)
      IDX_VEC0_ENABLE: rd_data[BYTE_W-1:0] = vec_enable_reg[0];
      IDX_VEC1_ENABLE: rd_data[BYTE_W-1:0] = vec_enable_reg[1];
      IDX_VEC2_ENABLE: rd_data[BYTE_W-1:0] = vec_enable_reg[2];
      IDX_VEC3_PIN_ENABLE_HIGH: rd_data[BYTE_W-1:0] = pin_enable_reg[15:8];
      IDX_VEC3_PIN_ENABLE_LOW: rd_data[BYTE_W-1:0] = pin_enable_reg[7:0];
      IDX_VEC0_EVENT_FLAGS: rd_data[BYTE_W-1:0] = src_flags_reg;
      IDX_VEC1_EVENT_FLAGS: rd_data[BYTE_W-1:0] = src_flags_reg;
      IDX_VEC2_EVENT_FLAGS: rd_data[BYTE_W-1:0] = src_flags_reg;
      IDX_VEC3_PIN_FLAGS_HIGH: rd_data[BYTE_W-1:0] = pin_flags_reg[15:8];
      IDX_VEC3_PIN_FLAGS_LOW: rd_data[BYTE_W-1:0] = pin_flags_reg[7:0];
      IDX_PIN_FLAG_CLEAR_HIGH: rd_data = '0;
      IDX_PIN_FLAG_CLEAR_LOW: rd_data = '0;
      default: req_mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so prdata comes from a flop;
  // no wait state is added, as pready is high in the first access cycle.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      apb_state_reg <= APB_IDLE;
    end else if (ce) begin
      unique case (apb_state_reg)
        APB_IDLE: if (psel && !penable) apb_state_reg <= APB_ARMED;
        APB_ARMED: if (psel && penable) apb_state_reg <= APB_IDLE;
        default: apb_state_reg <= APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_reg <= rd_data;
      pslverr_reg <= !req_mapped;
    end
  end

  assign pready = ce && psel && penable && (apb_state_reg == APB_ARMED);
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && pready;
  assign wr_fire = pready && req.pwrite && req_mapped;

  genvar v;
  generate
    for (v = 0; v < 3; v++) begin : g_vec_enable
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          vec_enable_reg[v] <= RESET_BYTE;
        end else if (ce && wr_fire && req_idx == IDX_VEC0_ENABLE + IDX_W'(v)) begin
          vec_enable_reg[v] <= req.pwdata[BYTE_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_enable_reg <= RESET_PINS;
    end else if (ce && wr_fire) begin
      if (req_idx == IDX_VEC3_PIN_ENABLE_HIGH) pin_enable_reg[15:8] <= req.pwdata[BYTE_W-1:0];
      if (req_idx == IDX_VEC3_PIN_ENABLE_LOW) pin_enable_reg[7:0] <= req.pwdata[BYTE_W-1:0];
    end
  end

  // ADC flag has no software clear; conversion completion clears it
  always_comb begin
    src_clear = periph_clear;
    src_clear.adc_event = periph_clear.adc_event || adc_conv_done;
  end

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      src_flags_reg <= RESET_BYTE;
    end else if (ce) begin
      src_flags_reg <= src_event | (src_flags_reg & ~src_clear);
    end
  end

  always_comb begin
    pin_clear = '0;
    if (wr_fire && req_idx == IDX_PIN_FLAG_CLEAR_HIGH) pin_clear[15:8] = req.pwdata[BYTE_W-1:0];
    if (wr_fire && req_idx == IDX_PIN_FLAG_CLEAR_LOW) pin_clear[7:0] = req.pwdata[BYTE_W-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_flags_reg <= RESET_PINS;
    end else if (ce) begin
      pin_flags_reg <= pin_event | (pin_flags_reg & ~pin_clear);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      vector_reg <= 4'h0;
    end else if (ce) begin
      vector_reg[0] <= |(src_flags_reg & vec_enable_reg[0]);
      vector_reg[1] <= |(src_flags_reg & vec_enable_reg[1]);
      vector_reg[2] <= |(src_flags_reg & vec_enable_reg[2]);
      vector_reg[3] <= |(pin_flags_reg & pin_enable_reg);
    end
  end

  assign ext_vector_zero = vector_reg[0];
  assign ext_vector_one = vector_reg[1];
  assign ext_vector_two = vector_reg[2];
  assign ext_vector_three = vector_reg[3];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_setup(logic [IDX_W-1:0] idx);
    ce && psel && !penable && pwrite && req_aligned && req_idx == idx;
  endsequence

  sequence s_access;
    ce && psel && penable && $stable(paddr) && $stable(pwdata);
  endsequence

  a_apb_wait_state: assert property (ce && psel && !penable ##1 ce && psel && penable |-> pready)
    else $error("access phase after setup not acknowledged");

  a_mask_low_write: assert property (s_setup(IDX_VEC3_PIN_ENABLE_LOW) ##1 s_access |=>
    pin_enable_reg[7:0] == $past(pwdata[7:0]))
    else $error("low pin mask did not take written byte");

  a_mask_high_write: assert property (s_setup(IDX_VEC3_PIN_ENABLE_HIGH) ##1 s_access |=>
    pin_enable_reg[15:8] == $past(pwdata[7:0]))
    else $error("high pin mask did not take written byte");

  a_src_flag_set: assert property (ce |=> (src_flags_reg & $past(src_event)) == $past(src_event))
    else $error("source event not flagged");

  a_adc_auto_clear: assert property (ce && adc_conv_done && !src_event.adc_event |=>
    !src_flags_reg.adc_event)
    else $error("adc flag survived conversion completion");

  a_periph_clear: assert property (ce |=>
    (src_flags_reg & $past(periph_clear & ~src_event)) == '0)
    else $error("peripheral clear did not drop its flag");

  a_flags_only_hw: assert property (ce && src_event == '0 && periph_clear == '0 && !adc_conv_done |=>
    $stable(src_flags_reg))
    else $error("source flags changed without a source");

  a_pin_flag_set: assert property (ce |=> (pin_flags_reg & $past(pin_event)) == $past(pin_event))
    else $error("pin event not flagged");

  a_pin_clear_low: assert property (s_setup(IDX_PIN_FLAG_CLEAR_LOW) ##1 s_access |=>
    (pin_flags_reg[7:0] & $past(pwdata[7:0] & ~pin_event[7:0])) == 8'h00)
    else $error("low pin flag clear ineffective");

  a_pin_clear_high: assert property (s_setup(IDX_PIN_FLAG_CLEAR_HIGH) ##1 s_access |=>
    (pin_flags_reg[15:8] & $past(pwdata[7:0] & ~pin_event[15:8])) == 8'h00)
    else $error("high pin flag clear ineffective");

  a_vec0_request: assert property (ce |=> ext_vector_zero == $past(|(src_flags_reg & vec_enable_reg[0])))
    else $error("vector zero request mismatch");

  a_vec3_request: assert property (ce ##1 ce |=> ext_vector_three ==
    $past(|(pin_flags_reg & pin_enable_reg)))
    else $error("vector three request mismatch");

  a_mask_freeze: assert property (!ce |=>
    $stable(pin_enable_reg))
    else $error("pin mask changed while clock enable low");

  a_src_freeze: assert property (!ce |=>
    $stable(src_flags_reg))
    else $error("source flags changed while clock enable low");

  a_pin_freeze: assert property (!ce |=>
    $stable(pin_flags_reg))
    else $error("pin flags changed while clock enable low");

  a_enable_freeze: assert property (!ce |=>
    $stable(vec_enable_reg[0]) && $stable(vec_enable_reg[1]) && $stable(vec_enable_reg[2]))
    else $error("vector enables changed while clock enable low");

  a_vec0_en_write: assert property (s_setup(IDX_VEC0_ENABLE) ##1 s_access |=>
    vec_enable_reg[0] == $past(pwdata[7:0]))
    else $error("vector zero enable did not take written byte");

  a_vec1_en_write: assert property (s_setup(IDX_VEC1_ENABLE) ##1 s_access |=>
    vec_enable_reg[1] == $past(pwdata[7:0]))
    else $error("vector one enable did not take written byte");

  a_vec2_en_write: assert property (s_setup(IDX_VEC2_ENABLE) ##1 s_access |=>
    vec_enable_reg[2] == $past(pwdata[7:0]))
    else $error("vector two enable did not take written byte");

  a_vec1_request: assert property (ce |=>
    ext_vector_one == $past(|(src_flags_reg & vec_enable_reg[1])))
    else $error("vector one request mismatch");

  a_vec2_request: assert property (ce |=>
    ext_vector_two == $past(|(src_flags_reg & vec_enable_reg[2])))
    else $error("vector two request mismatch");

  a_vec0_flag_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC0_EVENT_FLAGS |=>
    prdata == {24'h0, $past(src_flags_reg)})
    else $error("vector zero flag byte read wrong");

  a_vec1_flag_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC1_EVENT_FLAGS |=>
    prdata == {24'h0, $past(src_flags_reg)})
    else $error("vector one flag byte read wrong");

  a_vec2_flag_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC2_EVENT_FLAGS |=>
    prdata == {24'h0, $past(src_flags_reg)})
    else $error("vector two flag byte read wrong");

  a_pin_high_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC3_PIN_FLAGS_HIGH |=>
    prdata == {24'h0, $past(pin_flags_reg[15:8])})
    else $error("high pin flag byte read wrong");

  a_pin_low_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC3_PIN_FLAGS_LOW |=>
    prdata == {24'h0, $past(pin_flags_reg[7:0])})
    else $error("low pin flag byte read wrong");

  a_mask_low_read: assert property (ce && psel && !penable && req_aligned && req_idx == IDX_VEC3_PIN_ENABLE_LOW |=>
    prdata == {24'h0, $past(pin_enable_reg[7:0])})
    else $error("low pin mask read wrong");

  a_pin_flag_hold: assert property (ce && pin_event == '0 && !wr_fire |=>
    $stable(pin_flags_reg))
    else $error("pin flags changed without event or clear");

  a_flag_write_ignored: assert property (s_setup(IDX_VEC0_EVENT_FLAGS) ##1 s_access && src_event == '0 &&
    periph_clear == '0 && !adc_conv_done |=> $stable(src_flags_reg))
    else $error("write to flag byte altered flags");

  a_err_unmapped: assert property (ce && psel && !penable && !req_mapped ##1 ce && psel && penable |->
    pslverr)
    else $error("unmapped access not flagged as error");

  a_err_mapped: assert property (ce && psel && !penable && req_mapped ##1 ce && psel && penable |->
    !pslverr)
    else $error("mapped access flagged as error");

  a_spi_clear: assert property (ce && periph_clear.spi_event && !src_event.spi_event |=>
    !src_flags_reg.spi_event)
    else $error("spi flag survived its clear");

  a_comp_clear: assert property (ce && periph_clear.analog_comparator_event && !src_event.analog_comparator_event |=>
    !src_flags_reg.analog_comparator_event)
    else $error("comparator flag survived its clear");

  a_lvd_clear: assert property (ce && periph_clear.low_voltage_detect_event && !src_event.low_voltage_detect_event |=>
    !src_flags_reg.low_voltage_detect_event)
    else $error("low voltage flag survived its clear");

  a_watch_clear: assert property (ce && periph_clear.watch_timer_event && !src_event.watch_timer_event |=>
    !src_flags_reg.watch_timer_event)
    else $error("watch timer flag survived its clear");

  a_enhanced_timer_event_clear: assert property (ce && periph_clear.enhanced_timer_event && !src_event.enhanced_timer_event |=>
    !src_flags_reg.enhanced_timer_event)
    else $error("enhanced timer flag survived its clear");

  a_toggle_clear: assert property (ce && periph_clear.input_toggle_event && !src_event.input_toggle_event |=>
    !src_flags_reg.input_toggle_event)
    else $error("toggle flag survived its clear");

  a_reset_clean: assert property (disable iff (1'b0) !rstn |=>
    pin_flags_reg == '0 && src_flags_reg == '0 && pin_enable_reg == '0 && vec_enable_reg[0] == '0)
    else $error("state not zero after reset");

endmodule

// [hdl/irq_agg_pkg.sv]
package irq_agg_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int PIN_N = 16;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_VEC0_ENABLE = 10'h030;
  localparam logic [IDX_W-1:0] IDX_VEC1_ENABLE = 10'h031;
  localparam logic [IDX_W-1:0] IDX_VEC2_ENABLE = 10'h032;
  localparam logic [IDX_W-1:0] IDX_VEC3_PIN_ENABLE_HIGH = 10'h033;
  localparam logic [IDX_W-1:0] IDX_VEC3_PIN_ENABLE_LOW = 10'h034;
  localparam logic [IDX_W-1:0] IDX_VEC0_EVENT_FLAGS = 10'h035;
  localparam logic [IDX_W-1:0] IDX_VEC1_EVENT_FLAGS = 10'h036;
  localparam logic [IDX_W-1:0] IDX_VEC2_EVENT_FLAGS = 10'h037;
  localparam logic [IDX_W-1:0] IDX_VEC3_PIN_FLAGS_HIGH = 10'h038;
  localparam logic [IDX_W-1:0] IDX_VEC3_PIN_FLAGS_LOW = 10'h039;
  localparam logic [IDX_W-1:0] IDX_PIN_FLAG_CLEAR_HIGH = 10'h044;
  localparam logic [IDX_W-1:0] IDX_PIN_FLAG_CLEAR_LOW = 10'h045;

  localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [PIN_N-1:0] RESET_PINS = 16'h0000;

  // Source bit positions, shared by the vector 0-2 enable bytes and the event flag bytes
  localparam int BIT_SPI = 7;
  localparam int BIT_TWO_WIRE = 6;
  localparam int BIT_ADC = 5;
  localparam int BIT_COMPARATOR = 4;
  localparam int BIT_LOW_VOLTAGE = 3;
  localparam int BIT_WATCH_TIMER = 2;
  localparam int BIT_ENHANCED_TIMER = 1;
  localparam int BIT_INPUT_TOGGLE = 0;

  typedef struct packed {
    logic spi_event;
    logic two_wire_event;
    logic adc_event;
    logic analog_comparator_event;
    logic low_voltage_detect_event;
    logic watch_timer_event;
    logic enhanced_timer_event;
    logic input_toggle_event;
  } src_flags_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ARMED = 2'b01
  } apb_state_t;

endpackage

// [tb/irq_event_sources.sv]
`timescale 1ns/10ps
// Stands in for the peripherals and pin detectors; each request becomes a one-cycle set or clear pulse
module irq_event_sources
  import irq_agg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [BYTE_W-1:0] fire_set,
  input wire logic [BYTE_W-1:0] fire_clr,
  input wire logic fire_adc,
  input wire logic [PIN_N-1:0] fire_pin,
  output src_flags_t src_event,
  output src_flags_t periph_clear,
  output logic adc_conv_done,
  output logic [PIN_N-1:0] pin_event
);
  always_ff @(posedge sys_clk) begin
    src_event <= fire_set;
    pin_event <= fire_pin;
  end
  // Only the owning unit ever clears its flag; software has no path here
  always_ff @(posedge sys_clk) begin
    periph_clear <= fire_clr;
    adc_conv_done <= fire_adc;
  end
endmodule

// [tb/shared_interrupt_flag_aggregator_bench.sv]
`timescale 1ns/10ps
module shared_interrupt_flag_aggregator_bench;
  import irq_agg_pkg::*;
  typedef struct {logic [ADDR_W-1:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, v0, v1, v2, v3, fa = 1'b0, ce_run = 1'b1;
  logic [7:0] fs = '0, fc = '0;
  logic [PIN_N-1:0] fp = '0, pin_event;
  src_flags_t src_event, periph_clear;
  logic adc_conv_done;
  int n_mismatch = 0, cmp_count = 0;
  row_t rows [6] = '{'{12'h0C0, 8'hFF, 8'hFF}, '{12'h0C4, 8'h00, 8'h00}, '{12'h0C8, 8'hA5, 8'hA5},
    '{12'h0CC, 8'h10, 8'h10}, '{12'h0D0, 8'h08, 8'h08}, '{12'h0D4, 8'hFF, 8'h00}};
  always #5 sys_clk = ~sys_clk;
  irq_event_sources src (.sys_clk(sys_clk), .fire_set(fs), .fire_clr(fc), .fire_adc(fa), .fire_pin(fp),
    .src_event(src_event), .periph_clear(periph_clear), .adc_conv_done(adc_conv_done), .pin_event(pin_event));
  shared_interrupt_flag_aggregator dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce_run), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .periph_clear(periph_clear), .adc_conv_done(adc_conv_done),
    .pin_event(pin_event), .ext_vector_zero(v0), .ext_vector_one(v1), .ext_vector_two(v2),
    .ext_vector_three(v3));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Setup then access; request held until pready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    logic ok;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer is taken in the settled half before the edge that completes it
    do begin
      @(negedge sys_clk);
      ok = pready;
      rd = prdata;
      er = pslverr;
      n++;
      @(posedge sys_clk);
    end while (ok !== 1'b1 && n < 20);
    if (ok !== 1'b1) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input logic [7:0] s, input logic [7:0] c, input logic a, input logic [PIN_N-1:0] p);
    @(posedge sys_clk);
    fs <= s;
    fc <= c;
    fa <= a;
    fp <= p;
    @(posedge sys_clk);
    {fs, fc, fa, fp} <= '0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 'h30; i <= 'h39; i++) begin
      apb(1'b0, ADDR_W'(i * 4), 8'h00);
      chk(rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 8'h00);
      chk(rd, {24'h0, rows[i].e});
    end
    // Each source sets the same bit in all three flag bytes, then only its own clear removes it
    for (int b = 0; b < 8; b++) begin
      fire(8'(1 << b), 8'h00, 1'b0, '0);
      for (int a = 'h0D4; a <= 'h0DC; a += 4) begin
        apb(1'b0, ADDR_W'(a), 8'h00);
        chk(rd, 32'(1 << b));
      end
      chk({v0, v1, v2}, {1'b1, 1'b0, rows[2].w[b]});
      fire(8'h00, (b == BIT_ADC) ? 8'h00 : 8'(1 << b), b == BIT_ADC, '0);
      apb(1'b0, 12'h0D8, 8'h00);
      chk(rd, 32'h0);
      chk({v0, v2}, 2'b00);
    end
    fire(8'h00, 8'h00, 1'b0, 16'h0004);
    apb(1'b0, 12'h0E4, 8'h00);
    chk(rd, 32'h04);
    chk(v3, 1'b0);
    apb(1'b1, 12'h114, 8'h04);
    fire(8'h00, 8'h00, 1'b0, 16'h1008);
    apb(1'b0, 12'h0E0, 8'h00);
    chk(rd, 32'h10);
    chk(v3, 1'b1);
    apb(1'b1, 12'h110, 8'h10);
    apb(1'b0, 12'h0E0, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, 12'h114, 8'h08);
    apb(1'b0, 12'h0E4, 8'h00);
    chk(rd, 32'h0);
    chk(v3, 1'b0);
    apb(1'b0, 12'h200, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0C1, 8'h00);
    chk(er, 1'b1);
    apb(1'b0, 12'h0C0, 8'h00);
    chk(er, 1'b0);
    // A pin pulse while the clock enable is low must be lost
    @(posedge sys_clk);
    ce_run <= 1'b0;
    fire(8'h00, 8'h00, 1'b0, 16'h0001);
    ce_run <= 1'b1;
    apb(1'b0, 12'h0E4, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0C4, 8'h01);
    fire(8'h01, 8'h00, 1'b0, '0);
    chk(v1, 1'b1);
    // Reset in mid-run with state set
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    chk({v0, v1, v2, v3}, 4'h0);
    apb(1'b0, 12'h0C4, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0D8, 8'h00);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule
